// File: hw/snp_top.sv
// pair narrowing and pair predicate generation datapath, one cycle latency
// assumes the pipeline presents operands with the request and accepts
// the registered results one cycle later without stalling
`timescale 1ns/1ps
module snp_top #(
   parameter int unsigned VEC_LEN = snp_pkg::VEC_LEN_BITS
) (
   // clock and reset
   input  wire logic                                   clk_i,
   input  wire logic                                   reset_i,
   // configuration
   input  wire logic                                   feature_present_i,
   input  wire logic                                   data_independent_timing_i,
   // request
   input  wire logic                                   req_valid_i,
   input  wire snp_pkg::snp_op_t                       req_op_i,
   input  wire snp_pkg::snp_fields_t                   req_fields_i,
   // register read addresses
   output logic      [snp_pkg::SRC_PAIR_W:0]           src_even_idx_o,
   output logic      [snp_pkg::SRC_PAIR_W:0]           src_odd_idx_o,
   output logic      [snp_pkg::SCALAR_FLD_W-1:0]       first_scalar_idx_o,
   output logic      [snp_pkg::SCALAR_FLD_W-1:0]       second_scalar_idx_o,
   // register read data
   input  wire logic [VEC_LEN-1:0]                     src_even_i,
   input  wire logic [VEC_LEN-1:0]                     src_odd_i,
   input  wire logic [snp_pkg::SCALAR_BITS-1:0]        first_scalar_i,
   input  wire logic [snp_pkg::SCALAR_BITS-1:0]        second_scalar_i,
   // completion
   output logic                                        done_o,
   output logic                                        undefined_o,
   // vector write
   output logic                                        vec_we_o,
   output logic      [snp_pkg::DEST_VEC_W-1:0]         vec_dest_o,
   output logic      [VEC_LEN-1:0]                     vec_data_o,
   // predicate pair write
   output logic                                        pred_we_o,
   output logic      [snp_pkg::DEST_PRED_W:0]          pred_even_idx_o,
   output logic      [snp_pkg::DEST_PRED_W:0]          pred_odd_idx_o,
   output logic      [VEC_LEN/snp_pkg::PRED_UNIT_BITS-1:0] pred_even_o,
   output logic      [VEC_LEN/snp_pkg::PRED_UNIT_BITS-1:0] pred_odd_o,
   // condition flags write
   output logic                                        flags_we_o,
   output snp_pkg::snp_flags_t                         condition_flags_o
);

   // =========================================================
   // sizes derived from the vector length
   localparam int unsigned PRED_LEN  = VEC_LEN / snp_pkg::PRED_UNIT_BITS;
   localparam int unsigned PAIR_LEN  = 2 * PRED_LEN;
   localparam int unsigned NUM_PAIRS = VEC_LEN / (2 * snp_pkg::NARROW_BITS);
   localparam int unsigned NUM_LANES = 2 * NUM_PAIRS;

   typedef struct packed {
      logic                             done;
      logic                             undef;
      logic                             vec_we;
      logic [snp_pkg::DEST_VEC_W-1:0]   vec_dest;
      logic [VEC_LEN-1:0]               vec_data;
      logic                             pred_we;
      logic [snp_pkg::DEST_PRED_W:0]    pd_even;
      logic [snp_pkg::DEST_PRED_W:0]    pd_odd;
      logic [PAIR_LEN-1:0]              pred;
      logic                             flags_we;
      snp_pkg::snp_flags_t              flags;
   } snp_state_t;

   snp_state_t state_r;
   snp_state_t state_nxt;

   // =========================================================
   // register read addresses
   assign src_even_idx_o      = {req_fields_i.source_pair_field, snp_pkg::EVEN_REG};
   assign src_odd_idx_o       = {req_fields_i.source_pair_field, snp_pkg::ODD_REG};
   assign first_scalar_idx_o  = req_fields_i.first_scalar_field;
   assign second_scalar_idx_o = req_fields_i.second_scalar_field;

   // =========================================================
   // narrowing lanes, every element, no predicate
   logic                         round_sel;
   logic [snp_pkg::SHIFT_W-1:0]  shift_amt;
   logic [VEC_LEN-1:0]           narrow_res;

   assign round_sel = (req_op_i == snp_pkg::SNP_OP_ROUND_NARROW);
   assign shift_amt = snp_pkg::SHIFT_BASE -
                      {1'h0, req_fields_i.shift_immediate_field};

   for (genvar e = 0; e < NUM_PAIRS; e++) begin : g_pair
      for (genvar i = 0; i < 2; i++) begin : g_src
         snp_narrow_lane u_lane (
            .wide_i   (i == 0 ? src_even_i[e*snp_pkg::WIDE_BITS +: snp_pkg::WIDE_BITS]
                              : src_odd_i[e*snp_pkg::WIDE_BITS +: snp_pkg::WIDE_BITS]),
            .round_i  (round_sel),
            .shift_i  (shift_amt),
            .narrow_o (narrow_res[(2*e+i)*snp_pkg::NARROW_BITS +: snp_pkg::NARROW_BITS])
         );
      end
   end

   // =========================================================
   // compare steps, one per possible byte element of the pair
   logic                ge_sel;
   logic [PAIR_LEN-1:0] cond;

   assign ge_sel = (req_op_i == snp_pkg::SNP_OP_CMP_GE);

   for (genvar j = 0; j < PAIR_LEN; j++) begin : g_step
      snp_cmp_step #(
         .STEP (j)
      ) u_step (
         .first_i  (first_scalar_i),
         .second_i (second_scalar_i),
         .ge_i     (ge_sel),
         .cond_o   (cond[j])
      );
   end

   // =========================================================
   // predicate pair assembly
   logic [PAIR_LEN-1:0] pred_res;
   logic                top_true;
   logic                bottom_true;

   always_comb begin
      int unsigned count;
      int unsigned pos;
      logic        last;
      pos         = 0;
      count       = PAIR_LEN >> req_fields_i.size;
      pred_res    = '0;
      last        = 1'h1;
      top_true    = 1'h0;
      bottom_true = 1'h0;
      // j counts up from 0, which handles the highest element of the pair, then steps down
      for (int unsigned j = 0; j < PAIR_LEN; j++) begin
         if (j < count) begin
            last = last & cond[j];
            pos  = (count - 1 - j) << req_fields_i.size;
            pred_res[pos] = last;
            if (j == 0) begin
               top_true = last;
            end
            if (j == count - 1) begin
               bottom_true = last;
            end
         end
      end
   end

   // =========================================================
   // next state: every operation completes in one cycle
   always_comb begin
      state_nxt          = state_r;
      state_nxt.done     = 1'h0;
      state_nxt.undef    = 1'h0;
      state_nxt.vec_we   = 1'h0;
      state_nxt.pred_we  = 1'h0;
      state_nxt.flags_we = 1'h0;
      // latency and exception handling never depend on data or flags
      if (req_valid_i) begin
         state_nxt.done = 1'h1;
         if (!feature_present_i) begin
            state_nxt.undef = 1'h1;
         end else begin
            unique case (req_op_i)
               snp_pkg::SNP_OP_SAT_NARROW,
               snp_pkg::SNP_OP_ROUND_NARROW: begin
                  state_nxt.vec_we   = 1'h1;
                  state_nxt.vec_dest = req_fields_i.dest_vector_field;
                  state_nxt.vec_data = narrow_res;
               end
               snp_pkg::SNP_OP_CMP_GE,
               snp_pkg::SNP_OP_CMP_GT: begin
                  state_nxt.pred_we  = 1'h1;
                  state_nxt.flags_we = 1'h1;
                  state_nxt.pd_even  = {req_fields_i.dest_predicate_field,
                                        snp_pkg::EVEN_REG};
                  state_nxt.pd_odd   = {req_fields_i.dest_predicate_field,
                                        snp_pkg::ODD_REG};
                  state_nxt.pred     = pred_res;
                  state_nxt.flags.n  = bottom_true;
                  state_nxt.flags.z  = !top_true;
                  state_nxt.flags.c  = !top_true;
                  state_nxt.flags.v  = 1'h0;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   // =========================================================
   // outputs
   assign done_o            = state_r.done;
   assign undefined_o       = state_r.undef;
   assign vec_we_o          = state_r.vec_we;
   assign vec_dest_o        = state_r.vec_dest;
   assign vec_data_o        = state_r.vec_data;
   assign pred_we_o         = state_r.pred_we;
   assign pred_even_idx_o   = state_r.pd_even;
   assign pred_odd_idx_o    = state_r.pd_odd;
   assign pred_even_o       = state_r.pred[PRED_LEN-1:0];
   assign pred_odd_o        = state_r.pred[PAIR_LEN-1:PRED_LEN];
   assign flags_we_o        = state_r.flags_we;
   assign condition_flags_o = state_r.flags;

   // timing is data independent in every mode, so the bit has no effect
   logic unused_dit;
   assign unused_dit = data_independent_timing_i;

endmodule

// File: hw/snp_pkg.sv
// package for the pair narrowing and pair predicate datapath
// assumes one core clock, a synchronous active-high reset and a pipeline
// that reads the register files and writes the results back
package snp_pkg;

   // =========================================================
   // widths
   localparam int unsigned VEC_LEN_BITS   = 512;
   localparam int unsigned SCALAR_BITS    = 64;
   localparam int unsigned WIDE_BITS      = 32;
   localparam int unsigned NARROW_BITS    = 16;
   localparam int unsigned PRED_UNIT_BITS = 8;
   localparam int unsigned VEC_STEP_BITS  = 128;
   localparam int unsigned SHIFT_W        = 5;

   // =========================================================
   // instruction fields
   localparam int unsigned DEST_VEC_W    = 5;
   localparam int unsigned SRC_PAIR_W    = 4;
   localparam int unsigned IMM_W         = 4;
   localparam int unsigned DEST_PRED_W   = 3;
   localparam int unsigned SCALAR_FLD_W  = 5;
   localparam int unsigned SIZE_W        = 2;

   // =========================================================
   // constants used by the logic
   localparam logic [SHIFT_W-1:0]     SHIFT_BASE = 5'h10;
   localparam logic [NARROW_BITS-1:0] SAT_MAX    = 16'hFFFF;
   localparam logic                   ODD_REG    = 1'h1;
   localparam logic                   EVEN_REG   = 1'h0;

   // =========================================================
   // operations
   typedef enum logic [1:0] {
      SNP_OP_SAT_NARROW   = 2'h0,
      SNP_OP_ROUND_NARROW = 2'h1,
      SNP_OP_CMP_GE       = 2'h2,
      SNP_OP_CMP_GT       = 2'h3
   } snp_op_t;

   // predicate element size codes
   typedef enum logic [SIZE_W-1:0] {
      SNP_SZ_8  = 2'h0,
      SNP_SZ_16 = 2'h1,
      SNP_SZ_32 = 2'h2,
      SNP_SZ_64 = 2'h3
   } snp_size_t;

   typedef struct packed {
      logic [DEST_VEC_W-1:0]   dest_vector_field;
      logic [SRC_PAIR_W-1:0]   source_pair_field;
      logic [IMM_W-1:0]        shift_immediate_field;
      logic [DEST_PRED_W-1:0]  dest_predicate_field;
      logic [SCALAR_FLD_W-1:0] first_scalar_field;
      logic [SCALAR_FLD_W-1:0] second_scalar_field;
      snp_size_t               size;
   } snp_fields_t;

   typedef struct packed {
      logic n;
      logic z;
      logic c;
      logic v;
   } snp_flags_t;

endpackage

// File: hw/snp_narrow_lane.sv
// one narrowing lane: optional round-shift, then unsigned saturation to 16 bits
// assumes shift_i lies in 1..16 whenever round_i is high
`timescale 1ns/1ps
module snp_narrow_lane (
   // source
   input  wire logic [snp_pkg::WIDE_BITS-1:0]   wide_i,
   input  wire logic                            round_i,
   input  wire logic [snp_pkg::SHIFT_W-1:0]     shift_i,
   // result
   output logic      [snp_pkg::NARROW_BITS-1:0] narrow_o
);

   // one guard bit keeps the rounding sum from overflowing
   logic [snp_pkg::WIDE_BITS:0] round_const;
   logic [snp_pkg::WIDE_BITS:0] sum;
   logic [snp_pkg::WIDE_BITS:0] shifted;

   always_comb begin
      round_const = '0;
      sum         = {1'h0, wide_i};
      shifted     = sum;
      if (round_i) begin
         round_const[shift_i - 5'h01] = 1'h1;
         sum     = {1'h0, wide_i} + round_const;
         shifted = sum >> shift_i;
      end
      if (shifted > {{(snp_pkg::WIDE_BITS - snp_pkg::NARROW_BITS + 1){1'h0}},
                     snp_pkg::SAT_MAX}) begin
         narrow_o = snp_pkg::SAT_MAX;
      end else begin
         narrow_o = shifted[snp_pkg::NARROW_BITS-1:0];
      end
   end

endmodule

// File: hw/snp_cmp_step.sv
// one compare step: first scalar less STEP against the second, signed
// assumes both scalars are full 64-bit register values
`timescale 1ns/1ps
module snp_cmp_step #(
   parameter int unsigned STEP = 0
) (
   // operands
   input  wire logic [snp_pkg::SCALAR_BITS-1:0] first_i,
   input  wire logic [snp_pkg::SCALAR_BITS-1:0] second_i,
   input  wire logic                            ge_i,
   // result
   output logic                                 cond_o
);

   logic signed [snp_pkg::SCALAR_BITS-1:0] dec;

   // decrement wraps at 64 bits, as the register arithmetic does
   assign dec    = signed'(first_i - snp_pkg::SCALAR_BITS'(STEP));
   assign cond_o = ge_i ? (dec >= signed'(second_i))
                        : (dec >  signed'(second_i));

endmodule

// File: tb/snp_regs_model.sv
// register file stand-in for the pipeline side of the pair datapath
// assumes the bench loads contents by hierarchy while no request is pending
`timescale 1ns/1ps
module snp_regs_model #(
   parameter int unsigned VEC_LEN = 128
) (
   // read addresses
   input  wire logic [snp_pkg::SRC_PAIR_W:0]     vec_a_idx_i,
   input  wire logic [snp_pkg::SRC_PAIR_W:0]     vec_b_idx_i,
   input  wire logic [snp_pkg::SCALAR_FLD_W-1:0] x_a_idx_i,
   input  wire logic [snp_pkg::SCALAR_FLD_W-1:0] x_b_idx_i,
   // read data
   output logic      [VEC_LEN-1:0]               vec_a_o,
   output logic      [VEC_LEN-1:0]               vec_b_o,
   output logic      [snp_pkg::SCALAR_BITS-1:0]  x_a_o,
   output logic      [snp_pkg::SCALAR_BITS-1:0]  x_b_o
);
   logic [VEC_LEN-1:0]              vreg [32];
   logic [snp_pkg::SCALAR_BITS-1:0] xreg [32];
   // reads answer in the request cycle, as the pipeline does
   assign vec_a_o = vreg[vec_a_idx_i];
   assign vec_b_o = vreg[vec_b_idx_i];
   assign x_a_o   = xreg[x_a_idx_i];
   assign x_b_o   = xreg[x_b_idx_i];
endmodule

// File: tb/snp_top_props.sv
// concurrent checks on the ports of the pair datapath top
// assumes one clock and a synchronous active-high reset; bound from the bench
`timescale 1ns/1ps
module snp_top_props (
   // clock and reset
   input wire logic                             clk_i,
   input wire logic                             reset_i,
   // request side
   input wire logic                             feature_present_i,
   input wire logic                             req_valid_i,
   input wire snp_pkg::snp_op_t                 req_op_i,
   input wire snp_pkg::snp_fields_t             req_fields_i,
   input wire logic [snp_pkg::SRC_PAIR_W:0]     src_even_idx_o,
   input wire logic [snp_pkg::SRC_PAIR_W:0]     src_odd_idx_o,
   input wire logic [snp_pkg::SCALAR_FLD_W-1:0] first_scalar_idx_o,
   input wire logic [snp_pkg::SCALAR_FLD_W-1:0] second_scalar_idx_o,
   // answer side
   input wire logic                             done_o,
   input wire logic                             undefined_o,
   input wire logic                             vec_we_o,
   input wire logic [snp_pkg::DEST_VEC_W-1:0]   vec_dest_o,
   input wire logic                             pred_we_o,
   input wire logic [snp_pkg::DEST_PRED_W:0]    pred_even_idx_o,
   input wire logic [snp_pkg::DEST_PRED_W:0]    pred_odd_idx_o,
   input wire logic                             flags_we_o,
   input wire snp_pkg::snp_flags_t              condition_flags_o
);
   logic take_c;
   logic nar_c;
   assign take_c = req_valid_i && feature_present_i;
   assign nar_c  = (req_op_i == snp_pkg::SNP_OP_SAT_NARROW)
                || (req_op_i == snp_pkg::SNP_OP_ROUND_NARROW);
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (reset_i);
   // =========================================================
   // assertions
   a_answer_latency: assert property (req_valid_i |=> done_o)
      else $error("done missing one cycle after a request");
   a_no_stray_done: assert property (!req_valid_i |=> !done_o)
      else $error("done without a request");
   a_undef_answer: assert property ((req_valid_i && !feature_present_i) |=>
      undefined_o && !vec_we_o && !pred_we_o && !flags_we_o)
      else $error("absent feature not answered as undefined");
   a_defined_quiet: assert property (take_c |=> !undefined_o)
      else $error("undefined raised with feature present");
   a_narrow_write: assert property ((take_c && nar_c) |=> vec_we_o && !pred_we_o
      && vec_dest_o == $past(req_fields_i.dest_vector_field))
      else $error("narrow write missing or misdirected");
   a_pred_pair_write: assert property ((take_c && !nar_c) |=> pred_we_o && flags_we_o
      && !vec_we_o && pred_even_idx_o == {$past(req_fields_i.dest_predicate_field), 1'h0}
      && pred_odd_idx_o == {$past(req_fields_i.dest_predicate_field), 1'h1})
      else $error("predicate pair write missing or misdirected");
   a_src_pair_idx: assert property (src_even_idx_o == {req_fields_i.source_pair_field, 1'h0}
      && src_odd_idx_o == {req_fields_i.source_pair_field, 1'h1})
      else $error("source pair index wrong");
   a_scalar_idx: assert property (first_scalar_idx_o == req_fields_i.first_scalar_field
      && second_scalar_idx_o == req_fields_i.second_scalar_field)
      else $error("scalar index wrong");
   a_flags_shape: assert property (flags_we_o |-> !condition_flags_o.v
      && !(condition_flags_o.n && condition_flags_o.z))
      else $error("flags inconsistent");
   a_flags_hold: assert property (!flags_we_o |-> $stable(condition_flags_o))
      else $error("flags changed without a flags write");
   a_pred_idx_hold: assert property (!pred_we_o |-> $stable(pred_even_idx_o)
      && $stable(pred_odd_idx_o))
      else $error("predicate index changed without a write");
   c_narrow: cover property (take_c && nar_c);
   c_undef: cover property (req_valid_i && !feature_present_i);
   c_none_true: cover property (flags_we_o && condition_flags_o.z);
endmodule

// File: tb/snp_top_tb.sv
// self-checking bench for the pair narrowing and pair predicate datapath
// assumes the register file model answers reads in the request cycle
`timescale 1ns/1ps
module snp_top_tb;
   localparam int unsigned VL = 128;
   localparam int unsigned PW = VL / 8;
   logic clk_i = 1'h0;
   logic reset_i = 1'h1;
   logic feat = 1'h1;
   logic data_independent_timing = 1'h0;
   logic req_valid = 1'h0;
   snp_pkg::snp_op_t op = snp_pkg::SNP_OP_SAT_NARROW;
   snp_pkg::snp_fields_t f = '0;
   logic [4:0] se_idx, so_idx, xa_idx, xb_idx, vdest;
   logic [VL-1:0] se_d, so_d, vdata;
   logic [63:0] xa, xb;
   logic done, undef, vwe, pwe, fwe;
   logic [3:0] pe_idx, po_idx;
   logic [PW-1:0] pe, po;
   snp_pkg::snp_flags_t flags;
   int n_mismatch = 0;
   int n_checks = 0;
   snp_top #(.VEC_LEN(VL)) snp_top_i (.clk_i(clk_i), .reset_i(reset_i), .feature_present_i(feat),
      .data_independent_timing_i(data_independent_timing), .req_valid_i(req_valid), .req_op_i(op), .req_fields_i(f),
      .src_even_idx_o(se_idx), .src_odd_idx_o(so_idx), .first_scalar_idx_o(xa_idx),
      .second_scalar_idx_o(xb_idx), .src_even_i(se_d), .src_odd_i(so_d), .first_scalar_i(xa),
      .second_scalar_i(xb), .done_o(done), .undefined_o(undef), .vec_we_o(vwe), .vec_dest_o(vdest),
      .vec_data_o(vdata), .pred_we_o(pwe), .pred_even_idx_o(pe_idx), .pred_odd_idx_o(po_idx),
      .pred_even_o(pe), .pred_odd_o(po), .flags_we_o(fwe), .condition_flags_o(flags));
   snp_regs_model #(.VEC_LEN(VL)) snp_regs_model_i (.vec_a_idx_i(se_idx), .vec_b_idx_i(so_idx),
      .x_a_idx_i(xa_idx), .x_b_idx_i(xb_idx), .vec_a_o(se_d), .vec_b_o(so_d), .x_a_o(xa), .x_b_o(xb));
   initial begin
      forever #20 clk_i = ~clk_i;
   end
   // =========================================================
   // helpers
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input string what, input logic [VL-1:0] exp, input logic [VL-1:0] got);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic [15:0] nar(input logic [31:0] x, input logic rnd, input int imm);
      longint v;
      v = rnd ? (longint'(x) + (longint'(1) << (15 - imm))) >> (16 - imm) : longint'(x);
      return (v > 64'h000000000000FFFF) ? 16'hFFFF : v[15:0];
   endfunction
   function automatic logic [2*PW-1:0] pmk(input logic ge, input int sz, input longint a, input longint b);
      logic [2*PW-1:0] r;
      logic last;
      r = '0;
      last = 1'h1;
      for (int e = 2 * (VL >> (3 + sz)) - 1; e >= 0; e--) begin
         last = last && (ge ? a >= b : a > b);
         r[e << sz] = last;
         a = a - 1;
      end
      return r;
   endfunction
   // one request, answer judged in the following cycle
   task automatic issue(input snp_pkg::snp_op_t o);
      @(negedge clk_i);
      op = o;
      req_valid = 1'h1;
      @(negedge clk_i);
      req_valid = 1'h0;
      check("done", 1, done);
      check("undefined", !feat, undef);
      check("vector write", feat && !o[1], vwe);
      check("predicate write", feat && o[1], pwe && fwe);
   endtask
   // =========================================================
   // scenarios
   task automatic t_narrow(input logic rnd, input int imm);
      logic [VL-1:0] exp;
      f = '0;
      f.source_pair_field = 4'h5;
      f.dest_vector_field = 5'h1D;
      f.shift_immediate_field = 4'(imm);
      for (int e = 0; e < VL / 32; e++) begin
         exp[32*e+:16] = nar(snp_regs_model_i.vreg[10][32*e+:32], rnd, imm);
         exp[32*e+16+:16] = nar(snp_regs_model_i.vreg[11][32*e+:32], rnd, imm);
      end
      issue(rnd ? snp_pkg::SNP_OP_ROUND_NARROW : snp_pkg::SNP_OP_SAT_NARROW);
      check("vector data", exp, vdata);
      check("vector dest", 5'h1D, vdest);
      $display("narrow test done round %0d imm %0d", rnd, imm);
   endtask
   task automatic t_cmp(input snp_pkg::snp_op_t o, input int sz, input longint a, input longint b);
      logic [2*PW-1:0] exp;
      exp = pmk(o == snp_pkg::SNP_OP_CMP_GE, sz, a, b);
      snp_regs_model_i.xreg[7] = a;
      snp_regs_model_i.xreg[9] = b;
      f = '0;
      f.first_scalar_field = 5'h07;
      f.second_scalar_field = 5'h09;
      f.dest_predicate_field = 3'h5;
      f.size = snp_pkg::snp_size_t'(sz);
      issue(o);
      check("predicate pair", exp, {po, pe});
      check("predicate index", 8'hAB, {pe_idx, po_idx});
      check("flags", {exp[0], exp == '0, !exp[(2 * (VL >> (3 + sz)) - 1) << sz], 1'h0}, flags);
      $display("compare test done op %0d size %0d", o, sz);
   endtask
   task automatic t_undef();
      logic [VL-1:0] prev;
      prev = vdata;
      feat = 1'h0;
      issue(snp_pkg::SNP_OP_SAT_NARROW);
      issue(snp_pkg::SNP_OP_CMP_GT);
      check("vector data held", prev, vdata);
      feat = 1'h1;
      $display("undefined test done");
   endtask
   // =========================================================
   // main sequence
   initial begin
      for (int i = 0; i < 32; i++)
         snp_regs_model_i.vreg[i] = {16{8'(i)}};
      snp_regs_model_i.vreg[10] = 128'hFFFFFFFF_00010000_0000FFFF_00008000;
      snp_regs_model_i.vreg[11] = 128'h00000000_7FFF8000_00017FFF_12345678;
      repeat (2) @(negedge clk_i);
      reset_i = 1'h0;
      check("done after reset", 0, done);
      t_narrow(1'h0, 0);
      data_independent_timing = 1'h1;
      for (int i = 0; i < 16; i++) t_narrow(1'h1, i);
      for (int s = 0; s < 4; s++) begin
         t_cmp(snp_pkg::SNP_OP_CMP_GE, s, 20, 3);
         t_cmp(snp_pkg::SNP_OP_CMP_GT, s, 20, 3);
      end
      t_cmp(snp_pkg::SNP_OP_CMP_GE, 0, 64'h8000000000000002, 64'h8000000000000000);
      t_cmp(snp_pkg::SNP_OP_CMP_GT, 1, -5, 7);
      t_cmp(snp_pkg::SNP_OP_CMP_GT, 3, 7, -5);
      t_cmp(snp_pkg::SNP_OP_CMP_GE, 0, 1, -1);
      t_undef();
      end_of_test();
   end
   initial begin
      #400000;
      n_mismatch++;
      end_of_test();
   end
endmodule
bind snp_top snp_top_props snp_top_props_i (.clk_i(clk_i), .reset_i(reset_i),
   .feature_present_i(feature_present_i), .req_valid_i(req_valid_i), .req_op_i(req_op_i),
   .req_fields_i(req_fields_i), .src_even_idx_o(src_even_idx_o), .src_odd_idx_o(src_odd_idx_o),
   .first_scalar_idx_o(first_scalar_idx_o), .second_scalar_idx_o(second_scalar_idx_o),
   .done_o(done_o), .undefined_o(undefined_o), .vec_we_o(vec_we_o), .vec_dest_o(vec_dest_o),
   .pred_we_o(pred_we_o), .pred_even_idx_o(pred_even_idx_o), .pred_odd_idx_o(pred_odd_idx_o),
   .flags_we_o(flags_we_o), .condition_flags_o(condition_flags_o));
